// ---- ees_pkg.sv ----
// ==========================================================================
// shared constants and types of the serial eeprom slave
`default_nettype none
package ees_pkg;

	// ======================================================================
	// array geometry
	localparam int unsigned ADDR_W = 13;
	localparam int unsigned PAGE_W = 5;
	localparam int unsigned PAGE_BYTES = 32;
	localparam int unsigned MEM_BYTES = 8192;
	localparam logic [ADDR_W-1:0] PROT_BASE = 13'h1800;
	localparam logic [ADDR_W-1:0] PTR_RST = 13'h0000;

	// ======================================================================
	// control byte fields
	localparam logic [3:0] CTRL_CODE = 4'hA;
	localparam int unsigned CTRL_CODE_POS = 4;
	localparam int unsigned CTRL_CS_POS = 1;
	localparam int unsigned CTRL_RW_POS = 0;
	localparam logic [3:0] BIT_LAST = 4'h8;

	// ======================================================================
	// timing: nominal internal write cycle
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned WR_CYCLE_NS = 5000000;
	localparam int unsigned TMR_W = 21;
	localparam logic [TMR_W-1:0] WR_CYC_DEFAULT =
		TMR_W'(WR_CYCLE_NS / CLK_PERIOD_NS);

	// ======================================================================
	// pin group carried through the synchroniser
	typedef struct packed {
		logic scl;
		logic sda;
		logic wp;
		logic [2:0] cs;
	} ees_pins_type;

	localparam ees_pins_type PINS_RST = 6'h38;

	// one-hot protocol states
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_CTRL = 8'h02,
		ST_AHI = 8'h04,
		ST_ALO = 8'h08,
		ST_WDAT = 8'h10,
		ST_ACK = 8'h20,
		ST_RDAT = 8'h40,
		ST_MACK = 8'h80
	} ees_state_type;

endpackage : ees_pkg
`default_nettype wire

// ---- ees_slave.sv ----
`timescale 1ns/1ps
`default_nettype none

module ees_slave import ees_pkg::*; #(
	parameter logic [TMR_W-1:0] WR_CYCLES = WR_CYC_DEFAULT
) (
	input wire logic core_clk, // system clock, 250 MHz
	input wire logic rstn, // synchronous reset, active low
	input wire logic scl_in, // serial clock from the master
	input wire logic sda_in, // serial data line level
	input wire logic wp_in, // write protect pin
	input wire logic chip_select_bit0, // select strap 0
	input wire logic chip_select_bit1, // select strap 1
	input wire logic chip_select_bit2, // select strap 2
	output logic sda_out, // data drive value, always low
	output logic sda_oe_n, // low while pulling data line low
	output logic write_busy // internal write cycle running
);

	// ======================================================================
	// pin synchroniser and filter
	ees_pins_type pins_raw;
	ees_pins_type sync1_r, sync2_r, sync3_r, filt_r, prev_r, filt_nxt;

	assign pins_raw = '{scl: scl_in, sda: sda_in, wp: wp_in,
		cs: {chip_select_bit2, chip_select_bit1, chip_select_bit0}};
	// a bit moves only when the second and third stages agree
	assign filt_nxt = (sync2_r & sync3_r) | (filt_r & (sync2_r | sync3_r));

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			sync1_r <= PINS_RST;
			sync2_r <= PINS_RST;
			sync3_r <= PINS_RST;
			filt_r <= PINS_RST;
			prev_r <= PINS_RST;
		end else begin
			sync1_r <= pins_raw;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			filt_r <= filt_nxt;
			prev_r <= filt_r;
		end
	end

	// ======================================================================
	// bus condition decode
	wire logic scl_rise, scl_fall, bus_start, bus_stop;

	assign scl_rise = filt_r.scl & ~prev_r.scl;
	assign scl_fall = ~filt_r.scl & prev_r.scl;
	assign bus_start = filt_r.scl & prev_r.scl & prev_r.sda & ~filt_r.sda;
	assign bus_stop = filt_r.scl & prev_r.scl & ~prev_r.sda & filt_r.sda;

	// ======================================================================
	// state and storage
	ees_state_type state_r, state_nxt, ret_r, ret_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] rx_r, rx_nxt, tx_r, tx_nxt;
	logic [ADDR_W-1:0] ptr_r, ptr_nxt;
	logic oe_n_r, oe_n_nxt, pend_r, pend_nxt;
	logic [TMR_W-1:0] timer_r, timer_nxt;
	logic busy_r, buf_we, buf_clr, commit;
	wire logic [7:0] col_rd [PAGE_BYTES];
	logic [7:0] pbuf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] valid_r;

	// true when a page lies in the guarded quarter
	function automatic logic page_guarded(
		input logic [ADDR_W-PAGE_W-1:0] page);
		page_guarded = page >= PROT_BASE[ADDR_W-1:PAGE_W];
	endfunction : page_guarded

	wire logic ctrl_hit, rd_dir, wr_blocked, bit_done;
	wire logic [7:0] mem_rd;
	wire logic [ADDR_W-1:0] ptr_inc;
	wire logic [ADDR_W-1:0] ptr_page_inc;

	assign ctrl_hit = (rx_r[7:CTRL_CODE_POS] == CTRL_CODE) &&
		(rx_r[CTRL_CODE_POS-1:CTRL_CS_POS] == filt_r.cs) && !busy_r;
	assign rd_dir = rx_r[CTRL_RW_POS];
	assign wr_blocked = filt_r.wp && page_guarded(ptr_r[ADDR_W-1:PAGE_W]);
	assign bit_done = cnt_r == BIT_LAST;
	assign mem_rd = col_rd[ptr_r[PAGE_W-1:0]];
	// full-width wrap, top rolls to zero
	assign ptr_inc = ptr_r + 13'h0001;
	// only the low five bits count
	assign ptr_page_inc = {ptr_r[ADDR_W-1:PAGE_W],
		PAGE_W'(ptr_r[PAGE_W-1:0] + 5'h01)};

	// ======================================================================
	// protocol sequencer
	always_comb begin
		state_nxt = state_r;
		ret_nxt = ret_r;
		cnt_nxt = cnt_r;
		rx_nxt = rx_r;
		tx_nxt = tx_r;
		ptr_nxt = ptr_r;
		oe_n_nxt = oe_n_r;
		pend_nxt = pend_r;
		buf_we = 1'b0;
		buf_clr = 1'b0;
		commit = 1'b0;
		if (bus_start) begin
			// repeated start drops buffered data: only stop commits
			// pointer kept, nothing written
			state_nxt = ST_CTRL;
			cnt_nxt = 4'h0;
			oe_n_nxt = 1'b1;
			pend_nxt = 1'b0;
			buf_clr = 1'b1;
		end else if (bus_stop) begin
			state_nxt = ST_IDLE;
			oe_n_nxt = 1'b1;
			pend_nxt = 1'b0;
			buf_clr = 1'b1;
			// page goes to array on stop
			commit = pend_r && !wr_blocked;
		end else begin
			unique case (state_r)
				ST_CTRL, ST_AHI, ST_ALO, ST_WDAT: begin
					if (scl_rise && !bit_done) begin
						rx_nxt = {rx_r[6:0], filt_r.sda};
						cnt_nxt = cnt_r + 4'h1;
					end
					if (scl_fall && bit_done) begin
						cnt_nxt = 4'h0;
						oe_n_nxt = 1'b0;
						state_nxt = ST_ACK;
						unique case (state_r)
							ST_CTRL: begin
								// ack read or write control on ninth clock
								ret_nxt = rd_dir ? ST_RDAT : ST_AHI;
								if (!ctrl_hit) begin
									oe_n_nxt = 1'b1;
									state_nxt = ST_IDLE;
								end
							end
							ST_AHI: begin
								ptr_nxt[ADDR_W-1:8] = rx_r[ADDR_W-9:0];
								ret_nxt = ST_ALO;
							end
							ST_ALO: begin
								ptr_nxt[7:0] = rx_r;
								ret_nxt = ST_WDAT;
							end
							default: begin
								buf_we = 1'b1;
								pend_nxt = 1'b1;
								ptr_nxt = ptr_page_inc;
								ret_nxt = ST_WDAT;
							end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						state_nxt = ret_r;
						oe_n_nxt = 1'b1;
						if (ret_r == ST_RDAT) begin
							tx_nxt = mem_rd;
							ptr_nxt = ptr_inc;
							oe_n_nxt = mem_rd[7];
						end
					end
				end
				ST_RDAT: begin
					if (scl_rise && !bit_done) begin
						tx_nxt = {tx_r[6:0], 1'b1};
						cnt_nxt = cnt_r + 4'h1;
					end
					if (scl_fall) begin
						// release after eight bits so the master can answer
						oe_n_nxt = bit_done ? 1'b1 : tx_r[7];
						if (bit_done) begin
							state_nxt = ST_MACK;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						// master ack fetches the next byte
						// pointer already past the sent byte
						cnt_nxt = 4'h0;
						state_nxt = ST_IDLE;
						if (!filt_r.sda) begin
							tx_nxt = mem_rd;
							ptr_nxt = ptr_inc;
							state_nxt = ST_RDAT;
						end
					end
				end
				ST_IDLE: begin
					state_nxt = ST_IDLE;
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	assign timer_nxt = commit ? WR_CYCLES :
		(timer_r != '0) ? timer_r - 21'h000001 : timer_r;

	// ======================================================================
	// sequencer registers
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			ret_r <= ST_IDLE;
			cnt_r <= 4'h0;
			rx_r <= 8'h00;
			tx_r <= 8'hFF;
			ptr_r <= PTR_RST;
			oe_n_r <= 1'b1;
			pend_r <= 1'b0;
			timer_r <= '0;
			busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			ret_r <= ret_nxt;
			cnt_r <= cnt_nxt;
			rx_r <= rx_nxt;
			tx_r <= tx_nxt;
			ptr_r <= ptr_nxt;
			oe_n_r <= oe_n_nxt;
			pend_r <= pend_nxt;
			timer_r <= timer_nxt;
			busy_r <= timer_nxt != '0;
		end
	end

	// ======================================================================
	// page buffer; valid mask keeps unsent bytes of the page untouched
	always_ff @(posedge core_clk) begin
		if (!rstn || buf_clr) begin
			valid_r <= '0;
		end else if (buf_we) begin
			valid_r[ptr_r[PAGE_W-1:0]] <= 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (buf_we) begin
			pbuf[ptr_r[PAGE_W-1:0]] <= rx_r;
		end
	end

	// ======================================================================
	// array: one column per page offset, so each column has one writer;
	// the whole page lands in one cycle, timer models the delay
	for (genvar gi = 0; gi < PAGE_BYTES; gi++) begin : g_commit
		logic [7:0] col [MEM_BYTES/PAGE_BYTES];
		always_ff @(posedge core_clk) begin
			if (commit && valid_r[gi]) begin
				col[ptr_r[ADDR_W-1:PAGE_W]] <= pbuf[gi];
			end
		end
		// row read of this column; the offset mux picks one column
		assign col_rd[gi] = col[ptr_r[ADDR_W-1:PAGE_W]];
	end

	// data value tied low; enable and busy straight from flops
	assign sda_out = 1'b0;
	assign sda_oe_n = oe_n_r;
	assign write_busy = busy_r;

endmodule : ees_slave

`default_nettype wire

// ---- ees_mst.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// bus master model; scl rests high between frames
module ees_mst (
	input wire logic core_clk, // bench clock
	input wire logic sda_line, // resolved data line
	output var logic scl, // bus clock
	output var logic sda_drv_n // low while pulling data low
);
	logic s;
	// released lines float to the pull-up level
	initial begin
		scl = 1'b1;
		sda_drv_n = 1'b1;
	end
	// quarter bit of five clocks gives ten-clock scl phases
	task automatic q();
		repeat (5) @(posedge core_clk);
	endtask : q
	// callers change only one line per step, so no false start or stop
	task automatic p(input logic c, input logic b);
		q();
		scl <= c;
		sda_drv_n <= b;
	endtask : p
	// data moves while scl is low, sampled mid-high
	task automatic bit_io(input logic b, output logic v);
		p(1'b0, b);
		p(1'b1, b);
		q();
		v = sda_line;
		p(1'b0, b);
	endtask : bit_io
	task automatic start();
		p(1'b0, 1'b1);
		p(1'b1, 1'b1);
		p(1'b1, 1'b0);
		p(1'b0, 1'b0);
	endtask : start
	task automatic stop();
		p(1'b0, 1'b0);
		p(1'b1, 1'b0);
		p(1'b1, 1'b1);
		q();
	endtask : stop
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--)
			bit_io(b[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask : put_byte
	task automatic get_byte(input logic more, output logic [7:0] b);
		for (int i = 7; i >= 0; i--)
			bit_io(1'b1, b[i]);
		bit_io(!more, s);
	endtask : get_byte
endmodule : ees_mst
`default_nettype wire

// ---- ees_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// pin checks of the slave
module ees_chk import ees_pkg::*; #(
	parameter logic [TMR_W-1:0] WR_CYCLES = WR_CYC_DEFAULT
) (
	input wire logic core_clk, // system clock
	input wire logic rstn, // reset, active low
	input wire logic scl_in, // bus clock
	input wire logic sda_in, // data line
	input wire logic sda_out, // drive value
	input wire logic sda_oe_n, // drive enable, active low
	input wire logic write_busy // write cycle running
);
	logic [TMR_W-1:0] busy_cnt_r;
	// busy length; cleared while idle so each cycle counts afresh
	always_ff @(posedge core_clk) begin
		if (!rstn || !write_busy)
			busy_cnt_r <= '0;
		else
			busy_cnt_r <= busy_cnt_r + 1'b1;
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	// ======================================================================
	// assertions
	property p_od_low;
		!sda_oe_n |-> !sda_out;
	endproperty
	a_od_low: assert property (p_od_low) else $error("drive high");
	property p_oe_sclk;
		$changed(sda_oe_n) |-> !scl_in;
	endproperty
	a_oe_sclk: assert property (p_oe_sclk) else $error("scl high");
	property p_oe_hold;
		$fell(sda_oe_n) |-> !sda_oe_n [*8];
	endproperty
	a_oe_hold: assert property (p_oe_hold) else $error("short");
	property p_busy_quiet;
		write_busy |-> sda_oe_n;
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("ack");
	property p_busy_len;
		$fell(write_busy) |-> busy_cnt_r >= WR_CYCLES - 1'b1
			&& busy_cnt_r <= WR_CYCLES + 1'b1;
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("length");
	property p_busy_stop;
		$rose(write_busy) |-> $past(scl_in, 2) && $past(sda_in, 2);
	endproperty
	a_busy_stop: assert property (p_busy_stop) else $error("no stop");
	property p_busy_gap;
		$fell(write_busy) |-> !write_busy [*8];
	endproperty
	a_busy_gap: assert property (p_busy_gap) else $error("again");
	property p_start_free;
		scl_in && $fell(sda_in) |-> sda_oe_n;
	endproperty
	a_start_free: assert property (p_start_free) else $error("start");
endmodule : ees_chk
bind ees_slave ees_chk #(.WR_CYCLES(WR_CYCLES)) u_chk (.core_clk(core_clk),
	.rstn(rstn), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .write_busy(write_busy));
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// bench: array and pointer model beside the slave
module tb_top import ees_pkg::*;;
	localparam logic [TMR_W-1:0] WR_SIM = 21'h00190;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic wp = 1'b0;
	logic [2:0] cs = 3'h0;
	logic ack;
	logic [7:0] d;
	logic [7:0] mem [int];
	logic [7:0] pbuf [int];
	int ptr = 0;
	int errors = 0;
	int checks_done = 0;
	wire logic scl;
	wire logic drv_n;
	wire logic sda_out;
	wire logic sda_oe_n;
	wire logic write_busy;
	// open-drain line with pull-up
	wire logic line = drv_n & (sda_oe_n | sda_out);
	always #2 core_clk = ~core_clk;
	ees_mst u_mst (.core_clk(core_clk), .sda_line(line), .scl(scl),
		.sda_drv_n(drv_n));
	ees_slave #(.WR_CYCLES(WR_SIM)) u_dut (.core_clk(core_clk),
		.rstn(rstn), .scl_in(scl), .sda_in(line), .wp_in(wp),
		.chip_select_bit0(cs[0]), .chip_select_bit1(cs[1]),
		.chip_select_bit2(cs[2]), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .write_busy(write_busy));
	// compare and count
	task automatic chk(input string n, input logic [7:0] e,
		input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, g);
		end
	endtask : chk
	task automatic ctl(input logic [3:0] c, input logic [2:0] sel,
		input logic rw, input logic e);
		u_mst.start();
		u_mst.put_byte({c, sel, rw}, ack);
		chk("control ack", e, ack);
	endtask : ctl
	// upper three high address bits are random
	task automatic addr(input int a);
		ctl(CTRL_CODE, cs, 1'b0, 1'b1);
		u_mst.put_byte({3'($urandom), 5'(a >> 8)}, ack);
		chk("high address ack", 1'b1, ack);
		u_mst.put_byte(8'(a), ack);
		chk("low address ack", 1'b1, ack);
		ptr = a;
	endtask : addr
	task automatic wr(input int n);
		pbuf.delete();
		repeat (n) begin
			d = 8'($urandom);
			u_mst.put_byte(d, ack);
			chk("data ack", 1'b1, ack);
			pbuf[ptr] = d;
			ptr = (ptr & 32'h1FE0) | ((ptr + 1) & 32'h1F);
		end
	endtask : wr
	// stop; protection judged on the level present at the stop
	task automatic fin(input logic wp_after);
		logic hit;
		hit = !(wp && ptr >= 32'h1800);
		u_mst.stop();
		wp <= wp_after;
		repeat (8) @(posedge core_clk);
		chk("busy", 8'(hit), 8'(write_busy));
		if (hit) begin
			foreach (pbuf[a])
				mem[a] = pbuf[a];
			ctl(CTRL_CODE, cs, 1'b0, 1'b0);
			for (int i = 0; i < 6 && !ack; i++) begin
				u_mst.start();
				u_mst.put_byte({CTRL_CODE, cs, 1'b0}, ack);
			end
			chk("poll ack", 1'b1, ack);
		end else
			ctl(CTRL_CODE, cs, 1'b0, 1'b1);
		u_mst.stop();
	endtask : fin
	task automatic rd(input int n);
		ctl(CTRL_CODE, cs, 1'b1, 1'b1);
		for (int i = 0; i < n; i++) begin
			u_mst.get_byte(i < n - 1, d);
			if (mem.exists(ptr))
				chk("read data", mem[ptr], d);
			ptr = (ptr + 1) & 32'h1FFF;
		end
		u_mst.stop();
	endtask : rd
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	// watchdog well past the expected run of some 20000 clocks
	initial begin
		repeat (60000) @(posedge core_clk);
		errors++;
		report_and_stop();
	end
	// main sequence
	initial begin
		void'($urandom(87262));
		cs <= 3'($urandom);
		repeat (4) @(posedge core_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge core_clk);
		addr(32'h001E);
		wr(5);
		fin(1'b0);
		$display("test page wrap done");
		addr(32'h1FFF);
		wr(1);
		fin(1'b1);
		$display("test late protect done");
		addr(32'h1FFF);
		rd(3);
		rd(1);
		$display("test reads done");
		addr(32'h1FFF);
		wr(1);
		fin(1'b1);
		addr(32'h17FF);
		wr(1);
		fin(1'b1);
		addr(32'h17FF);
		rd(1);
		addr(32'h1FFF);
		rd(1);
		$display("test protect done");
		addr(32'h0040);
		wr(34);
		fin(1'b0);
		rd(1);
		addr(32'h0040);
		rd(2);
		$display("test overrun done");
		// other select codes are other devices' blocks
		for (int k = 1; k < 8; k++) begin
			ctl(CTRL_CODE, cs ^ 3'(k), 1'b0, 1'b0);
			u_mst.stop();
		end
		ctl(4'h5, cs, 1'b1, 1'b0);
		u_mst.stop();
		$display("test select done");
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
